// *** design/frs_host.sv ***
// Host-side reset sequencer for a parallel NOR flash: drives reset and select pins.
//
// Operation
// R1 - Device ignores controls during cold reset window.
// R2 - Access only by select falling after cold.
// R3 - Reset low at cold end holds reset.
// R4 - Reset high at cold end gives standby.
// R5 - Optional power-up reset honours pulse, recovery.
// R6 - Reset pulse at least 200 ns.
// R7 - Reset low to select low 35 us.
// R8 - Reset high 50 ns before select.
// R9 - Pulse plus high time covers recovery.
// R10 - Recovery counts from setup end if later.
// R11 - Select high pulse at least 20 ns.
// R12 - Warm reset aborts algorithm, no reload.
// R13 - After warm reset, standby when reset high.
// R14 - Unfinished cold reset makes reset cold.
// R15 - Ready/busy low throughout any reset.
// R16 - Reset starts when pin goes low.
// R17 - Keep select, enable high until intervals end.
`timescale 1ns/1ps
module frs_host #(
    parameter int unsigned SUPPLY_SETUP_CYC = frs_pkg::SUPPLY_SETUP_CYC,
    parameter int unsigned RESET_LOW_TO_SELECT_CYC = frs_pkg::RESET_LOW_TO_SELECT_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic power_up_hold,
    input wire logic reset_request,
    input wire logic access_select,
    input wire logic access_output,
    input wire logic ready_busy_n,
    output frs_pkg::frs_pins_t pins,
    output logic access_allowed,
    output logic device_busy
);

    // Local copies of the short counts sized to the counter.
    localparam logic [15:0] PULSE_CYC = 16'(frs_pkg::RESET_PULSE_MIN_CYC);
    localparam logic [15:0] HIGH_CYC = 16'(frs_pkg::RESET_HIGH_TO_SELECT_CYC);
    localparam logic [15:0] CEH_CYC = 16'(frs_pkg::SELECT_HIGH_PULSE_MIN_CYC);
    localparam logic [15:0] SETUP_CYC = 16'(SUPPLY_SETUP_CYC);
    localparam logic [15:0] RPH_CYC = 16'(RESET_LOW_TO_SELECT_CYC);

    // Synchronised ready/busy pin from the device.
    logic rdy_sync;
    // Current and next sequencer state.
    frs_pkg::frs_state_t state_reg, state_next;
    // Supply setup counter, runs once after controller reset.
    logic [15:0] setup_cnt_reg, setup_cnt_next;
    // Cycles since the later of reset pin fall and setup end (held at its ceiling).
    logic [15:0] low_cnt_reg, low_cnt_next;
    // Generic phase counter for pulse and high intervals.
    logic [15:0] phase_cnt_reg, phase_cnt_next;
    // Select-high pulse counter.
    logic [15:0] ceh_cnt_reg, ceh_cnt_next;
    // Registered pin outputs.
    logic reset_n_reg, reset_n_next;
    logic cs_n_reg, cs_n_next;
    logic oe_n_reg, oe_n_next;

    frs_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_rdy_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(ready_busy_n),
        .sync_out(rdy_sync)
    );

    // Decoded conditions as named wires.
    wire setup_done = (setup_cnt_reg >= SETUP_CYC);
    wire pulse_done = (phase_cnt_reg >= PULSE_CYC);
    // Recovery counted from the later of reset fall and setup end.
    wire recover_done = setup_done && (low_cnt_reg >= RPH_CYC); // see R10
    wire high_done = (phase_cnt_reg >= HIGH_CYC);
    wire ceh_done = (ceh_cnt_reg >= CEH_CYC);
    wire want_access = access_select || access_output;
    wire in_ready = (state_reg == frs_pkg::FRS_READY);

    // Setup counter saturates; the device ignores controls meanwhile.
    assign setup_cnt_next = setup_done ? setup_cnt_reg : setup_cnt_reg + 16'h0001; // see R1
    // Low counter restarts at the reset edge and only advances after setup.
    assign low_cnt_next = reset_n_reg ? 16'h0000 :
        ((setup_done && low_cnt_reg < RPH_CYC) ? low_cnt_reg + 16'h0001 : low_cnt_reg);
    // Select-high counter clears whenever select is low.
    assign ceh_cnt_next = !cs_n_reg ? 16'h0000 :
        (ceh_done ? ceh_cnt_reg : ceh_cnt_reg + 16'h0001);

    // Next-state logic of the sequencer.
    always_comb begin
        state_next = state_reg;
        phase_cnt_next = phase_cnt_reg + 16'h0001;
        reset_n_next = reset_n_reg;
        case (state_reg)
            frs_pkg::FRS_POWER_UP: begin
                // Optional reset during power-up; otherwise straight to standby wait.
                if (power_up_hold || reset_request) begin // see R5
                    state_next = frs_pkg::FRS_RESET_PULSE;
                    reset_n_next = 1'b0; // see R16
                    phase_cnt_next = 16'h0000;
                end else if (setup_done) begin // see R4
                    state_next = frs_pkg::FRS_RESET_HIGH;
                    phase_cnt_next = 16'h0000;
                end
            end
            frs_pkg::FRS_RESET_PULSE: begin
                // Hold reset for the minimum pulse; recovery counting runs alongside it.
                if (pulse_done) begin // see R6
                    state_next = frs_pkg::FRS_RESET_RECOVER;
                end
            end
            frs_pkg::FRS_RESET_RECOVER: begin
                // Stay in hardware reset while asked; release after recovery.
                if (recover_done && !reset_request && !power_up_hold) begin // see R3 R7 R9
                    state_next = frs_pkg::FRS_RESET_HIGH;
                    reset_n_next = 1'b1; // see R13
                    phase_cnt_next = 16'h0000;
                end
            end
            frs_pkg::FRS_RESET_HIGH: begin
                // Reset must be high a while before select may fall.
                if (reset_request) begin
                    state_next = frs_pkg::FRS_RESET_PULSE;
                    reset_n_next = 1'b0;
                    phase_cnt_next = 16'h0000;
                end else if (high_done && setup_done) begin // see R8
                    state_next = frs_pkg::FRS_READY;
                end
            end
            frs_pkg::FRS_READY: begin
                // A warm reset; device decides warm or cold by its own state.
                if (reset_request) begin // see R12 R14
                    state_next = frs_pkg::FRS_RESET_PULSE;
                    reset_n_next = 1'b0;
                    phase_cnt_next = 16'h0000;
                end
            end
            default: begin
                state_next = frs_pkg::FRS_POWER_UP;
            end
        endcase
        if (state_next != state_reg && phase_cnt_next != 16'h0000) begin
            phase_cnt_next = 16'h0000;
        end
        if (phase_cnt_reg == 16'hFFFF) begin
            phase_cnt_next = phase_cnt_reg;
        end
    end

    // Select and output enable: only in READY, and select may fall
    // only after its high pulse; a new fall gives a fresh edge.
    wire grant = in_ready && state_next == frs_pkg::FRS_READY && rdy_sync;
    assign cs_n_next = !(grant && want_access && (ceh_done || !cs_n_reg)); // see R2 R11 R17
    assign oe_n_next = !(grant && access_output && !cs_n_next); // see R17

    // State and counter registers.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= frs_pkg::FRS_POWER_UP;
            setup_cnt_reg <= 16'h0000;
            low_cnt_reg <= 16'h0000;
            phase_cnt_reg <= 16'h0000;
            ceh_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            setup_cnt_reg <= setup_cnt_next;
            low_cnt_reg <= low_cnt_next;
            phase_cnt_reg <= phase_cnt_next;
            ceh_cnt_reg <= ceh_cnt_next;
        end
    end

    // Pin registers; all pins idle high out of reset.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reset_n_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            reset_n_reg <= reset_n_next;
            cs_n_reg <= cs_n_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign pins.reset_n = reset_n_reg;
    assign pins.chip_select_n = cs_n_reg;
    assign pins.output_enable_n = oe_n_reg;
    assign access_allowed = in_ready;
    // Busy while sequencing or while the device reports busy.
    assign device_busy = !in_ready || !rdy_sync; // see R15

    // Select never falls before supply setup ends.
    chk_cs_after_setup: assert property (@(posedge mclk) disable iff (!resetn) // see R2
        $fell(cs_n_reg) |-> setup_cnt_reg >= SETUP_CYC)
        else $error("select fell before supply setup");
    // Reset pulse lasts the minimum width.
    chk_reset_pulse_width: assert property (@(posedge mclk) disable iff (!resetn) // see R6
        $fell(reset_n_reg) |-> !reset_n_reg [*5])
        else $error("reset pulse too short");
    // Reset rises only after recovery is satisfied.
    chk_reset_recovery: assert property (@(posedge mclk) disable iff (!resetn) // see R7
        $rose(reset_n_reg) |-> $past(low_cnt_reg) >= RPH_CYC)
        else $error("reset released before recovery");
    // Reset high for the minimum before select falls.
    chk_reset_high_sel: assert property (@(posedge mclk) disable iff (!resetn) // see R8
        $fell(cs_n_reg) |-> $past(reset_n_reg, 2))
        else $error("select fell too soon after reset");
    // Select high pulse minimum: a rising select stays high at least one more edge.
    chk_select_high: assert property (@(posedge mclk) disable iff (!resetn) // see R11
        $rose(cs_n_reg) |=> cs_n_reg)
        else $error("select high pulse too short");
    // Select never low while reset is low.
    chk_cs_reset_excl: assert property (@(posedge mclk) disable iff (!resetn) // see R17
        !reset_n_reg |-> cs_n_reg && oe_n_reg)
        else $error("access during reset");
    // Recovery only completes after setup.
    chk_recover_setup: assert property (@(posedge mclk) disable iff (!resetn) // see R10
        $rose(reset_n_reg) |-> setup_cnt_reg >= SETUP_CYC)
        else $error("recovery ended before setup");
    // Busy shown while in reset.
    chk_busy_reset: assert property (@(posedge mclk) disable iff (!resetn) // see R15
        !reset_n_reg |-> device_busy)
        else $error("not busy during reset");

    cov_warm_reset: cover property (@(posedge mclk) disable iff (!resetn)
        in_ready ##1 !reset_n_reg);
    cov_access: cover property (@(posedge mclk) disable iff (!resetn) $fell(cs_n_reg));
    cov_power_up_reset: cover property (@(posedge mclk) disable iff (!resetn)
        state_reg == frs_pkg::FRS_RESET_PULSE && !setup_done);

endmodule

// *** design/frs_pkg.sv ***
// Package with timing constants, states and carriers for the flash reset sequencer host.
package frs_pkg;

    // Clock period of mclk in picoseconds (25 MHz).
    localparam int unsigned CLK_PERIOD_PS = 40_000;

    // Supply setup times to first access, in microseconds.
    localparam int unsigned CORE_SUPPLY_SETUP_TIME_US = 300;
    localparam int unsigned IO_SUPPLY_SETUP_TIME_US = 300;
    // Reset low to select low, in microseconds.
    localparam int unsigned RESET_LOW_TO_SELECT_TIME_US = 35;
    // Reset pulse minimum, reset high to select, select high pulse, in nanoseconds.
    localparam int unsigned RESET_PULSE_MIN_NS = 200;
    localparam int unsigned RESET_HIGH_TO_SELECT_TIME_NS = 50;
    localparam int unsigned SELECT_HIGH_PULSE_MIN_NS = 20;

    // Cycle counts; least times round up.
    localparam int unsigned SUPPLY_SETUP_US_MAX =
        (CORE_SUPPLY_SETUP_TIME_US > IO_SUPPLY_SETUP_TIME_US) ?
        CORE_SUPPLY_SETUP_TIME_US : IO_SUPPLY_SETUP_TIME_US;
    localparam int unsigned SUPPLY_SETUP_CYC =
        (SUPPLY_SETUP_US_MAX * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESET_LOW_TO_SELECT_CYC =
        (RESET_LOW_TO_SELECT_TIME_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESET_PULSE_MIN_CYC =
        (RESET_PULSE_MIN_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESET_HIGH_TO_SELECT_CYC =
        (RESET_HIGH_TO_SELECT_TIME_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SELECT_HIGH_PULSE_MIN_CYC =
        (SELECT_HIGH_PULSE_MIN_NS * 1_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Width of the shared interval counter.
    localparam int unsigned CNT_W = 16;

    // Sequencer states.
    typedef enum logic [2:0] {
        FRS_POWER_UP,
        FRS_RESET_PULSE,
        FRS_RESET_RECOVER,
        FRS_RESET_HIGH,
        FRS_READY
    } frs_state_t;

    // Pins driven toward the flash device.
    typedef struct packed {
        logic reset_n;
        logic chip_select_n;
        logic output_enable_n;
    } frs_pins_t;

endpackage

// *** design/frs_sync.sv ***
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module frs_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage; read only by the second stage.
    logic [WIDTH-1:0] meta_reg;

    // Both stages load a constant under reset, then shift the pin in.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// *** verification/frs_flash_model.sv ***
// Behavioural flash device that answers the reset sequencer and polices its pin timing.
`timescale 1ns/1ps
module frs_flash_model #(
    parameter int unsigned COLD_CYC = 20,
    parameter int unsigned RPH_CYC = 10
) (
    input wire logic mclk,
    input wire logic power_on,
    input frs_pkg::frs_pins_t pins,
    output logic ready_busy_n,
    output logic [7:0] viol_count
);
    int unsigned cold_cnt; // Cycles of cold reset spent so far.
    int unsigned warm_cnt; // Cycles of warm reset spent so far.
    int unsigned low_cnt; // Length of the current reset pulse.
    int unsigned high_cnt; // Cycles since the reset pin last rose.
    logic cold_done; // Configuration load has finished.
    logic in_reset; // Device sits in the hardware reset state.
    logic cs_q; // Select as seen one edge earlier, to find its falling edge.
    logic standby; // Device is idle and accepts accesses.

    assign standby = cold_done && !in_reset;
    // Busy is pulled low for the whole of either reset; the pull-up gives high otherwise.
    assign ready_busy_n = standby;

    // Device state follows the pins; it only counts on mclk for convenience.
    always @(posedge mclk) begin
        if (!power_on) begin
            cold_cnt <= 0;
            warm_cnt <= 0;
            low_cnt <= 0;
            high_cnt <= 0;
            cold_done <= 1'b0;
            in_reset <= 1'b0;
            cs_q <= 1'b1;
            viol_count <= 8'h00;
        end else begin
            cs_q <= pins.chip_select_n;
            low_cnt <= pins.reset_n ? 0 : low_cnt + 1;
            high_cnt <= pins.reset_n ? high_cnt + 1 : 0;
            if (!cold_done) begin
                // Controls are ignored until the load ends; the reset level then decides.
                cold_cnt <= cold_cnt + 1;
                if (cold_cnt + 1 >= COLD_CYC) begin
                    cold_done <= 1'b1;
                    in_reset <= !pins.reset_n;
                    warm_cnt <= 0;
                end
            end else if (!pins.reset_n && !in_reset) begin
                // A low reset pin starts the warm algorithm and aborts any work.
                in_reset <= 1'b1;
                warm_cnt <= 0;
            end else if (in_reset) begin
                warm_cnt <= warm_cnt + 1;
                // Standby only once the algorithm is done and the pin is high.
                if (warm_cnt >= RPH_CYC && pins.reset_n) begin
                    in_reset <= 1'b0;
                end
            end
            // A reset pulse shorter than the minimum is a host fault.
            if (pins.reset_n && low_cnt != 0 && low_cnt < 5) begin
                viol_count <= viol_count + 8'h01;
            end
            // Select may fall only in standby and after reset stood high long enough.
            if (cs_q && !pins.chip_select_n && (!standby || high_cnt < 2)) begin
                viol_count <= viol_count + 8'h01;
            end
            if (!pins.output_enable_n && !standby) begin
                viol_count <= viol_count + 8'h01;
            end
        end
    end
endmodule

// *** verification/frs_host_tb_top.sv ***
// Self-checking testbench of the flash reset sequencer host.
`timescale 1ns/1ps
module frs_host_tb_top;
    logic mclk = 1'b0; // 25 MHz system clock.
    logic resetn = 1'b0; // Controller reset, also powers the device model.
    logic power_up_hold = 1'b0;
    logic reset_request = 1'b0;
    logic access_select = 1'b1; // Held from time zero to prove early accesses wait.
    logic access_output = 1'b0;
    logic ready_busy_n;
    frs_pkg::frs_pins_t pins;
    logic access_allowed;
    logic device_busy;
    logic [7:0] viol_count;
    int fail_count = 0;
    int compares = 0;

    always #20 mclk = ~mclk;

    // Shortened counts keep the run brief; the model uses the same figures.
    frs_host #(.SUPPLY_SETUP_CYC(20), .RESET_LOW_TO_SELECT_CYC(10)) i_dut (
        .mclk(mclk), .resetn(resetn), .power_up_hold(power_up_hold),
        .reset_request(reset_request), .access_select(access_select),
        .access_output(access_output), .ready_busy_n(ready_busy_n), .pins(pins),
        .access_allowed(access_allowed), .device_busy(device_busy));

    frs_flash_model #(.COLD_CYC(20), .RPH_CYC(10)) i_flash (
        .mclk(mclk), .power_on(resetn), .pins(pins),
        .ready_busy_n(ready_busy_n), .viol_count(viol_count));

    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask

    // Counts cycles until access is granted; select must stay high meanwhile.
    task automatic wait_allowed(output int n);
        n = 0;
        while (access_allowed !== 1'b1 && n < 400) begin
            check(pins.chip_select_n, 1'b1);
            @(negedge mclk);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            $display("mismatch at %0t: access never allowed", $time);
            final_report();
        end
    endtask

    task automatic do_reset(input logic hold);
        resetn = 1'b0;
        power_up_hold = hold;
        repeat (4) @(negedge mclk);
        check(pins.reset_n & pins.chip_select_n & pins.output_enable_n, 1'b1);
        check(device_busy, 1'b1);
        resetn = 1'b1;
    endtask

    // Cold start with an access already pending: nothing moves before setup ends.
    task automatic sc_cold();
        int n;
        do_reset(1'b0);
        wait_allowed(n);
        check(n >= 20, 1'b1);
        @(negedge mclk);
        check(pins.chip_select_n, 1'b0);
        check(pins.output_enable_n, 1'b1);
        access_output = 1'b1;
        repeat (2) @(negedge mclk);
        check(pins.output_enable_n, 1'b0);
        // The model's fault count clears with the next reset, so judge it here.
        check(viol_count == 8'h00, 1'b1);
    endtask

    // Reset held through setup: recovery is counted from the setup end.
    task automatic sc_hold();
        int n;
        access_output = 1'b0;
        do_reset(1'b1);
        repeat (22) @(negedge mclk);
        check(pins.reset_n, 1'b0);
        power_up_hold = 1'b0;
        wait_allowed(n);
        check(n >= 8, 1'b1);
        check(pins.reset_n, 1'b1);
    endtask

    // Warm reset from a live access: pulse long enough, select parked high.
    task automatic sc_warm();
        int w;
        int n;
        @(negedge mclk);
        check(pins.chip_select_n, 1'b0);
        reset_request = 1'b1;
        @(negedge mclk);
        reset_request = 1'b0;
        w = 0;
        while (pins.reset_n !== 1'b1 && w < 400) begin
            check(device_busy, 1'b1);
            @(negedge mclk);
            w++;
        end
        if (w >= 400) begin
            fail_count++;
            $display("mismatch at %0t: reset never released", $time);
            final_report();
        end
        check(w >= 10, 1'b1);
        check(pins.chip_select_n, 1'b1);
        wait_allowed(n);
        check(n >= 2, 1'b1);
    endtask

    // Back-to-back accesses keep a high gap on select.
    task automatic sc_gap();
        @(negedge mclk);
        access_select = 1'b0;
        @(negedge mclk);
        access_select = 1'b1;
        check(pins.chip_select_n, 1'b1);
        repeat (2) @(negedge mclk);
        check(pins.chip_select_n, 1'b0);
        check(device_busy, 1'b0);
    endtask

    initial begin
        sc_cold();
        sc_hold();
        sc_warm();
        sc_gap();
        check(viol_count == 8'h00, 1'b1);
        final_report();
    end
endmodule
